/* core/pwr_seq_pkg.sv */
// constants and carrier types for the power-up and wake sequencer
// assumes a 32-bit APB slave clocked by pclk at 125 MHz
package pwr_seq_pkg;

  // register byte offsets
  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  WAKE_MASK_OFS    = 8'h04;
  localparam logic [7:0]  STATUS_OFS       = 8'h08;
  localparam logic [7:0]  WAKE_CLEAR_OFS   = 8'h0c;

  // control register fields
  localparam int          PULSE_WIDTH_LSB  = 0;
  localparam int          PULSE_WIDTH_MSB  = 7;
  localparam int          FAST_DIRECT_BIT  = 8;
  localparam int          SLOW_DIRECT_BIT  = 9;
  localparam int          FAST_PD_BIT      = 10;
  localparam int          SLOW_PD_BIT      = 11;
  localparam int          CLK_SEL_BIT      = 12;
  localparam int          FORCE_FAST_BIT   = 13;
  localparam int          OK_IGNORE_BIT    = 14;
  localparam logic [31:0] CTRL_USED_MASK   = 32'h0000_7fff;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_1308;

  // wake mask: all sources blocked after reset
  localparam logic [31:0] WAKE_MASK_RESET  = 32'hffff_ffff;

  // wake sources that need the 32 kHz clock running
  localparam logic [31:0] SLOW_CLK_SOURCES = 32'h0000_0038;

  // regulator and oscillator defaults
  localparam logic        SWITCHING_MODE   = 1'b0;
  localparam logic [4:0]  TARGET_1V8       = 5'h10;
  localparam logic [1:0]  FAST_MODE_SI_4M  = 2'h0;
  localparam logic [7:0]  FAST_TRIM_RESET  = 8'h00;
  localparam logic        CLK_SRC_FAST     = 1'b1;

  // synchroniser depth, also the settle time after the load pulse
  localparam logic [7:0]  SYNC_SETTLE      = 8'h02;

  typedef enum logic [4:0] {
    ST_RESET     = 5'b00001,
    ST_LOAD      = 5'b00010,
    ST_WAIT_OK   = 5'b00100,
    ST_ACTIVE    = 5'b01000,
    ST_WAKE_LOCK = 5'b10000
  } seq_state_e;

  typedef struct packed {
    logic       powerdown;
    logic [1:0] mode;
    logic [7:0] trim;
  } fast_osc_s;

  typedef struct packed {
    logic       mode_select;
    logic [4:0] target_voltage;
  } regulator_ctl_s;

endpackage

/* core/power_up_wake_sequencer.sv */
// power-up reset sequencer and sleep wake path with an APB register file
// assumes presetn is the external reset pin; other inputs are synchronous
// to pclk except the regulator ok and the latched wake, which are resynced
//
// Overview of operation
// - reset pin low drives power-on, cold and warm resets low together.
// - during reset both oscillators enabled, fast one 4 MHz, trim zero.
// - reset pin release frees only power-on reset; cold and warm stay.
// - after power-on release one load pulse selects switching mode at 1.8 V.
// - load pulse width comes from the programmable width field.
// - regulator drops its ok output on the load pulse rising edge.
// - wait for regulator ok; a bypassed regulator counts as always ok.
// - on ok release cold and warm resets and enable cpu, sram, flash clocks.
// - in sleep any enabled wake event is captured and held.
// - a held wake removes the slow oscillator powerdown at once.
// - a held wake removes the fast oscillator powerdown at once.
// - wake clock follows select field once the resynced wake rises; force bit picks fast.
// - when the clock runs again after wake, raise the wake interrupt.
// - direct bit set: the powerdown bit drives the oscillator directly.
// - wake mask bit 0 enables a source, 1 blocks; software sets all after wake.
// - no internal reset is asserted on sleep entry or exit.
// - sleep entry is done by firmware; the sequencer only follows it.
// - without the slow clock only level gpio, comparator, probe, reset wake.
// - direct bit clear: powerdown waits until the processor halts.
`timescale 1ns/1ns
`default_nettype none
module power_up_wake_sequencer (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        regulator_in_regulation,
  input  wire logic                        regulator_bypass_pin,
  output logic                             regulator_voltage_load_pulse,
  output pwr_seq_pkg::regulator_ctl_s      regulator_control,
  output pwr_seq_pkg::fast_osc_s           fast_osc_control,
  output logic                             slow_osc_powerdown,
  input  wire logic                        fast_osc_locked,
  input  wire logic                        slow_osc_locked,
  input  wire logic                        cpu_halted,
  input  wire logic [31:0]                 wake_events,
  output logic                             system_clock_source_select,
  output logic                             por_rst_n,
  output logic                             cold_rst_n,
  output logic                             warm_rst_n,
  output logic                             cpu_clk_en,
  output logic                             sram_clk_en,
  output logic                             flash_clk_en,
  output logic                             wake_interrupt
);
  import pwr_seq_pkg::*;

  seq_state_e  state_reg;
  seq_state_e  state_next;
  logic [31:0] ctrl_reg;
  logic [31:0] wake_mask_reg;
  logic [1:0]  rst_sync_reg;
  logic [1:0]  ok_sync_reg;
  logic [1:0]  wake_sync_reg;
  logic        wake_seen_d_reg;
  logic        wake_latched_reg;
  logic        sleep_reg;
  logic [7:0]  cnt_reg;
  logic [7:0]  pulse_len_reg;
  logic        pulse_reg;
  logic        fast_pd_reg;
  logic        slow_pd_reg;
  logic        clk_sel_reg;
  logic        irq_reg;
  logic        cold_reg;
  logic        por_reg;
  logic        clk_en_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  logic        apb_access;
  logic        apb_write;
  logic        ok_eff;
  logic        wake_rise;
  logic        lock_ok;
  logic        wake_clear;
  logic [31:0] wake_enabled;
  logic [7:0]  pulse_width;

  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == CTRL_OFS) || (a == WAKE_MASK_OFS) || (a == STATUS_OFS) ||
           (a == WAKE_CLEAR_OFS);
  endfunction

  function automatic logic [7:0] at_least_one(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction

  // apb: one wait state, write and read data at the pready edge
  assign apb_access = psel && penable && pready_reg;
  assign apb_write  = apb_access && pwrite && addr_mapped(paddr);
  assign wake_clear = apb_write && (paddr == WAKE_CLEAR_OFS) && pwdata[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !addr_mapped(paddr);
      if (psel && penable && !pready_reg && !pwrite) begin
        case (paddr)
          CTRL_OFS:      prdata_reg <= ctrl_reg;
          WAKE_MASK_OFS: prdata_reg <= wake_mask_reg;
          STATUS_OFS:    prdata_reg <= {16'h0000, 3'h0, state_reg, ok_eff,
                                        wake_latched_reg, irq_reg, clk_sel_reg,
                                        slow_pd_reg, fast_pd_reg, cold_reg, por_reg};
          default:       prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= CTRL_RESET;
      wake_mask_reg <= WAKE_MASK_RESET;
    end else if (apb_write) begin
      if (paddr == CTRL_OFS) begin
        ctrl_reg <= pwdata & CTRL_USED_MASK;
      end
      if (paddr == WAKE_MASK_OFS) begin
        wake_mask_reg <= pwdata;
      end
    end
  end

  // synchronisers; first stages feed only second stages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_reg    <= 2'b00;
      ok_sync_reg     <= 2'b00;
      wake_sync_reg   <= 2'b00;
      wake_seen_d_reg <= 1'b0;
    end else begin
      rst_sync_reg    <= {rst_sync_reg[0], 1'b1};
      ok_sync_reg     <= {ok_sync_reg[0], regulator_in_regulation};
      wake_sync_reg   <= {wake_sync_reg[0], wake_latched_reg};
      wake_seen_d_reg <= wake_sync_reg[1];
    end
  end

  assign ok_eff      = regulator_bypass_pin || ok_sync_reg[1] ||
                       ctrl_reg[OK_IGNORE_BIT];
  assign wake_rise   = wake_sync_reg[1] && !wake_seen_d_reg;
  assign pulse_width = at_least_one(ctrl_reg[PULSE_WIDTH_MSB:PULSE_WIDTH_LSB]);
  assign lock_ok     = (ctrl_reg[FORCE_FAST_BIT] || ctrl_reg[CLK_SEL_BIT]) ?
                       fast_osc_locked : slow_osc_locked;
  // sources needing the slow clock only count while it runs
  assign wake_enabled = wake_events & ~wake_mask_reg &
                        (slow_pd_reg ? ~SLOW_CLK_SOURCES : 32'hffff_ffff);

  // sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET:     if (rst_sync_reg[1]) state_next = ST_LOAD;
      ST_LOAD:      if (cnt_reg == pulse_width) state_next = ST_WAIT_OK;
      ST_WAIT_OK:   if (cnt_reg >= SYNC_SETTLE && ok_eff) state_next = ST_ACTIVE;
      ST_ACTIVE:    if (wake_rise) state_next = ST_WAKE_LOCK;
      ST_WAKE_LOCK: if (lock_ok) state_next = ST_ACTIVE;
      default:      state_next = ST_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_RESET;
      cnt_reg   <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 8'h01;
      end else if (cnt_reg != 8'hff) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // resets: asserted asynchronously, released on the clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_reg    <= 1'b0;
      cold_reg   <= 1'b0;
      clk_en_reg <= 1'b0;
    end else begin
      por_reg <= rst_sync_reg[1];
      if (state_reg == ST_WAIT_OK && state_next == ST_ACTIVE) begin
        cold_reg   <= 1'b1;
        clk_en_reg <= 1'b1;
      end
    end
  end

  // regulator load pulse, width counted from its rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_reg     <= 1'b0;
      pulse_len_reg <= 8'h00;
    end else begin
      if (state_reg == ST_RESET && rst_sync_reg[1]) begin
        pulse_reg <= 1'b1;
      end else if (state_reg == ST_LOAD && cnt_reg == pulse_width) begin
        pulse_reg <= 1'b0;
      end
      pulse_len_reg <= pulse_reg ? pulse_len_reg + 8'h01 : 8'h00;
    end
  end

  // sleep tracking and wake capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg        <= 1'b0;
      wake_latched_reg <= 1'b0;
    end else begin
      sleep_reg <= (state_reg == ST_ACTIVE) && cpu_halted;
      if (sleep_reg && (|wake_enabled)) begin
        wake_latched_reg <= 1'b1;
      end else if (wake_clear) begin
        wake_latched_reg <= 1'b0;
      end
    end
  end

  // oscillator powerdowns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_pd_reg <= 1'b0;
      slow_pd_reg <= 1'b0;
    end else if (state_reg != ST_ACTIVE || wake_latched_reg ||
                 (sleep_reg && (|wake_enabled))) begin
      fast_pd_reg <= 1'b0;
      slow_pd_reg <= 1'b0;
    end else begin
      fast_pd_reg <= ctrl_reg[FAST_PD_BIT] &&
                     (ctrl_reg[FAST_DIRECT_BIT] || cpu_halted);
      slow_pd_reg <= ctrl_reg[SLOW_PD_BIT] &&
                     (ctrl_reg[SLOW_DIRECT_BIT] || cpu_halted);
    end
  end

  // wake clock select and interrupt; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_sel_reg <= CLK_SRC_FAST;
      irq_reg     <= 1'b0;
    end else begin
      if (state_reg == ST_ACTIVE && wake_rise) begin
        clk_sel_reg <= ctrl_reg[FORCE_FAST_BIT] ? CLK_SRC_FAST :
                       ctrl_reg[CLK_SEL_BIT];
      end
      if (state_reg == ST_WAKE_LOCK && lock_ok) begin
        irq_reg <= 1'b1;
      end else if (wake_clear) begin
        irq_reg <= 1'b0;
      end
    end
  end

  assign prdata                       = prdata_reg;
  assign pready                       = pready_reg;
  assign pslverr                      = pslverr_reg;
  assign regulator_voltage_load_pulse = pulse_reg;
  assign regulator_control            = '{mode_select: SWITCHING_MODE,
                                          target_voltage: TARGET_1V8};
  assign fast_osc_control             = '{powerdown: fast_pd_reg, mode: FAST_MODE_SI_4M,
                                          trim: FAST_TRIM_RESET};
  assign slow_osc_powerdown           = slow_pd_reg;
  assign system_clock_source_select   = clk_sel_reg;
  assign por_rst_n                    = por_reg;
  assign cold_rst_n                   = cold_reg;
  assign warm_rst_n                   = cold_reg;
  assign cpu_clk_en                   = clk_en_reg;
  assign sram_clk_en                  = clk_en_reg;
  assign flash_clk_en                 = clk_en_reg;
  assign wake_interrupt               = irq_reg;

  // checks
  sequence por_release_s;
    $rose(por_reg) && cold_reg == 1'b0;
  endsequence

  sequence load_pulse_s;
    $rose(pulse_reg) && state_reg == ST_LOAD;
  endsequence

  sequence wake_capture_s;
    sleep_reg && (|wake_enabled);
  endsequence

  por_only_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(por_reg) |-> !cold_reg && !warm_rst_n)
    else $error("cold or warm reset left with power-on reset");

  load_after_por_a: assert property (@(posedge pclk) disable iff (!presetn)
    por_release_s |-> load_pulse_s)
    else $error("load pulse did not follow power-on release");

  pulse_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(pulse_reg) |-> $past(pulse_len_reg) + 8'h01 == pulse_width)
    else $error("load pulse width differs from width field");

  ok_before_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cold_reg) |-> $past(ok_eff) && $past(state_reg) == ST_WAIT_OK)
    else $error("resets released without regulator ok");

  release_clocks_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cold_reg) |-> cpu_clk_en && sram_clk_en && flash_clk_en && warm_rst_n)
    else $error("clocks not enabled with reset release");

  no_reset_active_a: assert property (@(posedge pclk) disable iff (!presetn)
    cold_reg |=> cold_reg && por_reg)
    else $error("internal reset asserted after start-up");

  wake_osc_on_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wake_latched_reg) |-> !fast_pd_reg && !slow_pd_reg)
    else $error("oscillator still powered down on wake");

  wake_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wake_latched_reg) |-> $past(|(wake_events & ~wake_mask_reg)))
    else $error("wake captured from a masked source");

  force_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_WAKE_LOCK && ctrl_reg[FORCE_FAST_BIT] && $stable(ctrl_reg)
      |-> clk_sel_reg == CLK_SRC_FAST)
    else $error("wake clock not forced to fast oscillator");

  wake_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_reg) |-> $past(state_reg) == ST_WAKE_LOCK && $past(lock_ok))
    else $error("wake interrupt raised outside lock step");

  reset_all_low_a: assert property (@(posedge pclk)
    !presetn |=> !por_reg && !cold_reg && !warm_rst_n)
    else $error("internal reset not asserted with reset pin");

  osc_on_reset_a: assert property (@(posedge pclk)
    !presetn |=> !fast_pd_reg && !slow_pd_reg)
    else $error("oscillator powered down during reset");

  ok_settle_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(cold_reg) |-> $past(cnt_reg) >= SYNC_SETTLE)
    else $error("resets released before regulator ok settled");

  wake_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_latched_reg && !wake_clear |=> wake_latched_reg)
    else $error("held wake lost without a clear");

  wake_pd_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_capture_s |=> wake_latched_reg && !slow_pd_reg && !fast_pd_reg)
    else $error("oscillators not restarted on wake capture");

  pd_deferred_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[FAST_DIRECT_BIT] && !cpu_halted |=> !fast_pd_reg)
    else $error("fast oscillator powered down before halt");

  pd_direct_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_ACTIVE && !wake_latched_reg && !sleep_reg && ctrl_reg[FAST_DIRECT_BIT]
      |=> fast_pd_reg == $past(ctrl_reg[FAST_PD_BIT]))
    else $error("fast powerdown bit not applied directly");

endmodule
`default_nettype wire

/* test/regulator_osc_model.sv */
// behavioural model of the on-die regulator and both oscillators
// assumes pulse and powerdown inputs come from the sequencer on pclk
`timescale 1ns/1ns
`default_nettype none
module regulator_osc_model #(
  parameter int OK_DELAY   = 20,
  parameter int LOCK_DELAY = 6
) (
  input  wire logic pclk,
  input  wire logic load_pulse,
  input  wire logic bypass_pin,
  input  wire logic fast_pd,
  input  wire logic slow_pd,
  output logic      in_regulation,
  output logic      fast_locked,
  output logic      slow_locked
);
  logic pulse_q = 1'b0;
  logic ok_q    = 1'b1;
  int   ok_cnt  = 0;
  int   f_cnt   = 0;
  int   s_cnt   = 0;

  // regulator is not reset by the reset pin, only by a supply cycle
  always @(posedge pclk) begin
    pulse_q <= load_pulse;
    if (bypass_pin) begin
      ok_q <= 1'b1;
    end else if (load_pulse && !pulse_q) begin
      ok_q   <= 1'b0;
      ok_cnt <= OK_DELAY;
    end else if (!load_pulse && ok_cnt > 0) begin
      ok_cnt <= ok_cnt - 1;
      if (ok_cnt == 1) ok_q <= 1'b1;
    end
  end

  // lock is lost at once on powerdown, regained after a restart delay
  always @(posedge pclk) begin
    f_cnt <= fast_pd ? 0 : (f_cnt < LOCK_DELAY ? f_cnt + 1 : f_cnt);
    s_cnt <= slow_pd ? 0 : (s_cnt < LOCK_DELAY ? s_cnt + 1 : s_cnt);
  end

  assign in_regulation = ok_q;
  assign fast_locked   = !fast_pd && f_cnt >= LOCK_DELAY;
  assign slow_locked   = !slow_pd && s_cnt >= LOCK_DELAY;
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the power-up and wake sequencer
// assumes the regulator/oscillator model on the far side and an APB master here
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pwr_seq_pkg::*;
  localparam int OK_DLY = 20;
  logic           pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic           pwrite = 1'b0, bypass = 1'b0, halted = 1'b0;
  logic [7:0]     paddr = 8'h00;
  logic [31:0]    pwdata = 32'h0, wake_ev = 32'h0, prdata;
  logic           pready, pslverr, ok, pulse, slow_pd, flock, slock, clk_sel;
  logic           por, cold, warm, cpu_en, sram_en, flash_en, wake_irq;
  regulator_ctl_s reg_ctl;
  fast_osc_s      fosc;
  logic           in_wake = 1'b0, rst_drop = 1'b0;
  int             fail_count = 0, check_count = 0;

  always #4 pclk = ~pclk;

  power_up_wake_sequencer u_power_up_wake_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regulator_in_regulation(ok), .regulator_bypass_pin(bypass),
    .regulator_voltage_load_pulse(pulse), .regulator_control(reg_ctl),
    .fast_osc_control(fosc), .slow_osc_powerdown(slow_pd), .fast_osc_locked(flock),
    .slow_osc_locked(slock), .cpu_halted(halted), .wake_events(wake_ev),
    .system_clock_source_select(clk_sel), .por_rst_n(por), .cold_rst_n(cold),
    .warm_rst_n(warm), .cpu_clk_en(cpu_en), .sram_clk_en(sram_en),
    .flash_clk_en(flash_en), .wake_interrupt(wake_irq));

  regulator_osc_model #(.OK_DELAY(OK_DLY), .LOCK_DELAY(6)) u_regulator_osc_model (
    .pclk(pclk), .load_pulse(pulse), .bypass_pin(bypass), .fast_pd(fosc.powerdown),
    .slow_pd(slow_pd), .in_regulation(ok), .fast_locked(flock), .slow_locked(slock));

  always @(posedge pclk) begin
    if (in_wake && {por, cold, warm} !== 3'b111) rst_drop <= 1'b1;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("apb_answer", 32'd1, {31'd0, n < 20});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ex_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'd0, ex_err}, {31'd0, e});
  endtask

  task automatic test_reset(input logic byp);
    int w;
    int t;
    w = 0;
    t = 0;
    @(posedge pclk);
    presetn <= 1'b0;
    bypass  <= byp;
    repeat (12) @(posedge pclk);
    #1;
    chk("rst_all", 32'd0, {29'd0, por, cold, warm});
    chk("osc_pd", 32'd0, {30'd0, fosc.powerdown, slow_pd});
    chk("fast_cfg", {22'd0, FAST_MODE_SI_4M, FAST_TRIM_RESET}, {22'd0, fosc.mode, fosc.trim});
    chk("reg_ctl", {26'd0, SWITCHING_MODE, TARGET_1V8}, {26'd0, reg_ctl});
    @(posedge pclk);
    presetn <= 1'b1;
    while (por !== 1'b1 && t < 10) begin
      @(posedge pclk);
      #1;
      t++;
    end
    chk("cold_held", 32'd0, {30'd0, cold, warm});
    chk("pulse_start", 32'd1, {31'd0, pulse});
    t = 0;
    while (cold !== 1'b1 && t < 200) begin
      if (pulse === 1'b1) w++;
      @(posedge pclk);
      #1;
      t++;
    end
    chk("pulse_width", {24'd0, CTRL_RESET[PULSE_WIDTH_MSB:PULSE_WIDTH_LSB]}, w);
    if (byp) chk("bypass_fast", 32'd1, {31'd0, t <= 8 + 4});
    else chk("ok_waited", 32'd1, {31'd0, t >= 8 + OK_DLY && t < 200});
    chk("released", 32'h1f, {27'd0, por, warm, cpu_en, sram_en, flash_en});
    $display("test reset bypass=%0d done", byp);
  endtask

  task automatic test_registers;
    rd(CTRL_OFS, CTRL_RESET, 1'b0);
    rd(WAKE_MASK_OFS, WAKE_MASK_RESET, 1'b0);
    rd(STATUS_OFS, {19'd0, ST_ACTIVE, 8'h93}, 1'b0);
    wr(8'h10, 32'h0000_00ff);
    rd(8'h10, 32'h0, 1'b1);
    rd(CTRL_OFS, CTRL_RESET, 1'b0);
    wr(WAKE_MASK_OFS, 32'h1234_5678);
    rd(WAKE_MASK_OFS, 32'h1234_5678, 1'b0);
    $display("test registers done");
  endtask

  task automatic test_wake;
    int t;
    t = 0;
    in_wake = 1'b1;
    wr(WAKE_MASK_OFS, 32'hffff_fff6);
    wr(CTRL_OFS, 32'h0000_6c08);
    repeat (3) @(posedge pclk);
    #1;
    chk("pd_deferred", 32'd0, {30'd0, fosc.powerdown, slow_pd});
    @(posedge pclk);
    halted <= 1'b1;
    repeat (4) @(posedge pclk);
    #1;
    chk("pd_on_halt", 32'd3, {30'd0, fosc.powerdown, slow_pd});
    @(posedge pclk);
    wake_ev <= 32'h0000_000a;
    repeat (6) @(posedge pclk);
    #1;
    chk("no_wake", 32'd3, {30'd0, fosc.powerdown, slow_pd});
    // bit 0 stands for the probe request, a level needing no slow clock
    @(posedge pclk);
    wake_ev <= 32'h0000_0001;
    while (slow_pd !== 1'b0 && t < 4) begin
      @(posedge pclk);
      #1;
      t++;
    end
    chk("pd_removed", 32'd0, {30'd0, fosc.powerdown, slow_pd});
    t = 0;
    while (wake_irq !== 1'b1 && t < 60) begin
      @(posedge pclk);
      #1;
      t++;
    end
    chk("wake_irq", 32'd1, {31'd0, wake_irq});
    chk("clk_fast", {31'd0, CLK_SRC_FAST}, {31'd0, clk_sel});
    @(posedge pclk);
    halted  <= 1'b0;
    wake_ev <= 32'h0;
    wr(WAKE_MASK_OFS, 32'hffff_ffff);
    wr(WAKE_CLEAR_OFS, 32'h0000_0001);
    #1;
    chk("irq_clear", 32'd0, {31'd0, wake_irq});
    in_wake = 1'b0;
    chk("no_reset", 32'd0, {31'd0, rst_drop});
    wr(CTRL_OFS, 32'h0000_0708);
    repeat (2) @(posedge pclk);
    #1;
    chk("pd_direct", 32'd2, {30'd0, fosc.powerdown, slow_pd});
    $display("test wake done");
  endtask

  initial begin
    test_reset(1'b0);
    test_registers();
    test_wake();
    test_reset(1'b1);
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    print_verdict();
  end
endmodule
`default_nettype wire
